/* rtl/ext_bank_map.vh */
`ifndef EXT_BANK_MAP_VH
`define EXT_BANK_MAP_VH
// Instruction fetch windows in bank 0 (word addresses)
`define NORM_FETCH_LO   32'h0020_0000
`define NORM_FETCH_HI   32'h005F_FFFF
`define SHORT_FETCH_LO  32'h0060_0000
`define SHORT_FETCH_HI  32'h00FF_FFFF
// Synchronous bank windows
`define SD_B0_LO        32'h0020_0000
`define SD_B0_HI        32'h03FF_FFFF
`define SD_BANK_SHIFT   26
// Asynchronous bank windows
`define AS_B0_LO        32'h0020_0000
`define AS_B0_HI        32'h007F_FFFF
`define AS_BN_MASK      32'h0380_0000
// Wait count width and extra buffer cycles
`define TIME_W          4
`define XBUF_EXTRA      4'h1
// Bank size codes: 4 MB << code, codes 0..6 legal
`define SIZE_MAX_CODE   3'h6
`define SIZE_4MB_WORDS  32'h0010_0000
// Fetch kinds
`define KIND_DATA       2'h0
`define KIND_NORM_FETCH 2'h1
`define KIND_SHORT_FETCH 2'h2
`endif

/* rtl/bank_timing_mem.v */
`include "ext_bank_map.vh"
// Per-bank timing store, four entries, registered read data
module bank_timing_mem
(
    // Clock
    input  wire                 i_mclk,
    // Write side
    input  wire                 i_we,
    input  wire [1:0]           i_waddr,
    input  wire [`TIME_W-1:0]   i_wdata,
    // Read side
    input  wire [1:0]           i_raddr,
    output reg  [`TIME_W-1:0]   o_rdata
);
    reg [`TIME_W-1:0] mem [0:3];    // One wait count per bank

    // Write and registered read
    always @(posedge i_mclk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // bank_timing_mem

/* rtl/external_memory_bank_map.v */
`include "ext_bank_map.vh"
module external_memory_bank_map
(
    // Clock and reset
    input  wire                 i_mclk,
    input  wire                 i_rst,
    // Memory side clock pin, sampled
    input  wire                 i_sdram_clk,
    // Configuration
    input  wire [3:0]           i_bank_is_sync,
    input  wire [11:0]          i_bank_size_code,
    input  wire                 i_ext_buffer_timing,
    input  wire                 i_compressed_instruction_mode,
    input  wire                 i_tim_we,
    input  wire [1:0]           i_tim_bank,
    input  wire [`TIME_W-1:0]   i_tim_wait,
    // Core request
    input  wire                 i_core_req,
    input  wire [31:0]          i_core_addr,
    input  wire                 i_core_fetch,
    output wire                 o_core_gnt,
    // DMA request
    input  wire                 i_dma_req,
    input  wire [31:0]          i_dma_addr,
    output wire                 o_dma_gnt,
    // Results
    output reg  [3:0]           o_bank_select_n,
    output reg                  o_busy,
    output reg                  o_done,
    output reg                  o_fault,
    output reg  [1:0]           o_kind,
    output reg  [1:0]           o_instr_per_fetch
);
    // ****************************************************
    // Decode functions
    // ****************************************************

    // Bank hit for a word address; returns one-hot bank bits
    function [3:0] bank_hit;
        input [31:0] a;
        input [3:0]  is_sync;
        input [11:0] size_code;
        integer      b;
        reg   [31:0] base;
        reg   [31:0] lim;
        reg   [31:0] lo;
        begin
            bank_hit = 4'h0;
            for (b = 0; b < 4; b = b + 1)
            begin
                base = b << `SD_BANK_SHIFT;
                if (is_sync[b])
                begin
                    lo  = (b == 0) ? `SD_B0_LO : base;
                    // Populated size in words from code
                    lim = base + (`SIZE_4MB_WORDS
                          << size_code[3*b +: 3]) - 32'h1;
                    if (lim > base + `SD_B0_HI)
                    begin
                        lim = base + `SD_B0_HI;
                    end
                    if (a >= lo && a <= lim)
                    begin
                        bank_hit[b] = 1'b1;
                    end
                end
                else
                begin
                    // Fixed async window, no remap
                    lo  = (b == 0) ? `AS_B0_LO : base;
                    lim = (b == 0) ? `AS_B0_HI
                                   : base + 32'h007F_FFFF;
                    if (a >= lo && a <= lim)
                    begin
                        bank_hit[b] = 1'b1;
                    end
                end
            end
        end
    endfunction

    // Fetch legality: bank zero windows only
    function [1:0] fetch_kind;
        input [31:0] a;
        begin
            if (a >= `NORM_FETCH_LO && a <= `NORM_FETCH_HI)
            begin
                fetch_kind = `KIND_NORM_FETCH;
            end
            else if (a >= `SHORT_FETCH_LO && a <= `SHORT_FETCH_HI)
            begin
                fetch_kind = `KIND_SHORT_FETCH;
            end
            else
            begin
                fetch_kind = `KIND_DATA;
            end
        end
    endfunction

    // One-hot bank bits to a bank index
    function [1:0] onehot_idx;
        input [3:0] h;
        begin
            onehot_idx = h[3] ? 2'h3 : h[2] ? 2'h2 :
                         h[1] ? 2'h1 : 2'h0;
        end
    endfunction

    // ****************************************************
    // Link clock sampling
    // ****************************************************

    reg [2:0] sclk_sync_r;      // Three-stage pin sampler
    reg       sclk_lvl_r;       // Filtered level
    wire      sclk_rise;        // One-cycle edge enable

    // Level changes only when stages two and three agree
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            sclk_sync_r <= 3'h0;
            sclk_lvl_r  <= 1'b0;
        end
        else
        begin
            sclk_sync_r <= {sclk_sync_r[1:0], i_sdram_clk};
            if (sclk_sync_r[1] == sclk_sync_r[2])
            begin
                sclk_lvl_r <= sclk_sync_r[2];
            end
        end
    end

    assign sclk_rise = (sclk_sync_r[1] == sclk_sync_r[2])
                       && sclk_sync_r[2] && !sclk_lvl_r;

    // ****************************************************
    // Arbitration
    // ****************************************************

    localparam ST_IDLE = 2'h0;
    localparam ST_LOAD = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_DONE = 2'h3;

    reg  [1:0]          state_r;      // Cycle sequencer
    reg  [1:0]          state_nxt;
    reg                 last_dma_r;   // Round robin memory
    reg  [31:0]         addr_r;       // Latched address
    reg                 fetch_r;      // Latched fetch flag
    reg  [3:0]          hit_r;        // Latched bank hit
    reg  [`TIME_W-1:0]  wait_r;       // Remaining wait
    wire                pick_dma;
    wire [`TIME_W-1:0]  tim_rdata;
    wire [1:0]          bank_idx;
    wire [31:0]         win_addr;     // Address of the winner
    wire [3:0]          win_hit;      // Winner's decoded bank
    wire [1:0]          tim_raddr;    // Timing lookup index

    // Alternate grants when both ask, so neither starves
    assign pick_dma   = i_dma_req && (!i_core_req || !last_dma_r);
    assign o_core_gnt = (state_r == ST_IDLE) && i_core_req
                        && !pick_dma;
    assign o_dma_gnt  = (state_r == ST_IDLE) && pick_dma;

    // Winner decoded once, shared by the latch and the lookup
    assign win_addr = pick_dma ? i_dma_addr : i_core_addr;
    assign win_hit  = bank_hit(win_addr, i_bank_is_sync,
                               i_bank_size_code);
    assign bank_idx = onehot_idx(hit_r);
    // Store reads a cycle late: address it at the grant so
    // the load cycle sees this bank's count, not the last one
    assign tim_raddr = (state_r == ST_IDLE) ? onehot_idx(win_hit)
                                            : bank_idx;

    // Per-bank timing store, one entry per bank
    bank_timing_mem u_tim
    (
        .i_mclk  (i_mclk),
        .i_we    (i_tim_we),
        .i_waddr (i_tim_bank),
        .i_wdata (i_tim_wait),
        .i_raddr (tim_raddr),
        .o_rdata (tim_rdata)
    );

    // ****************************************************
    // Sequencer
    // ****************************************************

    // Next state
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (o_core_gnt || o_dma_gnt)
                begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                // Unmapped or illegal fetch ends at once
                if (hit_r == 4'h0 ||
                    (fetch_r && fetch_kind(addr_r) == `KIND_DATA))
                begin
                    state_nxt = ST_DONE;
                end
                else
                begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (wait_r == {`TIME_W{1'b0}} &&
                    (!hit_r[bank_idx] || sclk_rise ||
                     !i_bank_is_sync[bank_idx]))
                begin
                    state_nxt = ST_DONE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Registers and outputs
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_r           <= ST_IDLE;
            last_dma_r        <= 1'b0;
            addr_r            <= 32'h0;
            fetch_r           <= 1'b0;
            hit_r             <= 4'h0;
            wait_r            <= {`TIME_W{1'b0}};
            o_bank_select_n   <= 4'hF;
            o_busy            <= 1'b0;
            o_done            <= 1'b0;
            o_fault           <= 1'b0;
            o_kind            <= `KIND_DATA;
            o_instr_per_fetch <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            o_done  <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (o_core_gnt || o_dma_gnt)
                    begin
                        // Latch winner and decode its bank
                        addr_r     <= win_addr;
                        fetch_r    <= !pick_dma && i_core_fetch;
                        last_dma_r <= pick_dma;
                        hit_r      <= win_hit;
                        o_busy     <= 1'b1;
                        o_fault    <= 1'b0;
                    end
                end
                ST_LOAD:
                begin
                    if (state_nxt == ST_DONE)
                    begin
                        o_fault <= 1'b1;
                    end
                    else
                    begin
                        // Only the decoded bank goes low
                        o_bank_select_n <= ~hit_r;
                        // Buffered option adds a cycle
                        wait_r <= tim_rdata + (i_ext_buffer_timing
                                  ? `XBUF_EXTRA : {`TIME_W{1'b0}});
                        o_kind <= fetch_r ? fetch_kind(addr_r)
                                          : `KIND_DATA;
                        // Short code packs three per 48-bit fetch
                        o_instr_per_fetch <= !fetch_r ? 2'h0 :
                            (fetch_kind(addr_r) == `KIND_SHORT_FETCH
                             && i_compressed_instruction_mode)
                            ? 2'h3 : 2'h1;
                    end
                end
                ST_WAIT:
                begin
                    if (wait_r != {`TIME_W{1'b0}})
                    begin
                        wait_r <= wait_r - {{(`TIME_W-1){1'b0}}, 1'b1};
                    end
                end
                default:
                begin
                    o_bank_select_n <= 4'hF;
                    o_busy          <= 1'b0;
                    o_done          <= 1'b1;
                end
            endcase
        end
    end
endmodule // external_memory_bank_map

/* tb/bank_map_sva.sv */
`include "ext_bank_map.vh"
// Port checker for the bank map, watches design outputs and the mode input
module bank_map_sva
(
    // Clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rst,
    // Mode input
    input wire logic       i_compressed_instruction_mode,
    // Observed outputs
    input wire logic       o_core_gnt,
    input wire logic       o_dma_gnt,
    input wire logic [3:0] o_bank_select_n,
    input wire logic       o_busy,
    input wire logic       o_done,
    input wire logic       o_fault,
    input wire logic [1:0] o_kind,
    input wire logic [1:0] o_instr_per_fetch
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Some select is low
    wire any_sel;
    assign any_sel = (o_bank_select_n != 4'hF);
    a_one_select: assert property ($onehot0(~o_bank_select_n))
        else $error("two selects low");
    a_fault_quiet: assert property (o_fault |-> !any_sel)
        else $error("select low during fault");
    a_one_grant: assert property (!(o_core_gnt && o_dma_gnt))
        else $error("both grants");
    a_grant_idle: assert property ((o_core_gnt || o_dma_gnt) |->
        !o_busy ##1 o_busy) else $error("grant not from idle");
    a_fetch_bank: assert property ((any_sel && o_kind != `KIND_DATA) |->
        o_bank_select_n == 4'hE) else $error("fetch outside bank 0");
    a_short_three: assert property ((any_sel &&
        o_kind == `KIND_SHORT_FETCH && i_compressed_instruction_mode)
        |-> o_instr_per_fetch == 2'h3)
        else $error("short fetch count");
    a_normal_one: assert property ((any_sel &&
        o_kind == `KIND_NORM_FETCH) |-> o_instr_per_fetch == 2'h1)
        else $error("normal fetch count");
    a_done_free: assert property (
        o_done |-> !any_sel && !o_busy ##1 !o_done)
        else $error("done not released");
    a_sel_busy: assert property (any_sel |-> o_busy)
        else $error("select while idle");
    a_sel_hold: assert property ((any_sel && $past(any_sel)) |->
        $stable(o_bank_select_n)) else $error("select moved");
endmodule // bank_map_sva

bind external_memory_bank_map bank_map_sva u_sva
(
    .i_mclk(i_mclk), .i_rst(i_rst), .o_core_gnt(o_core_gnt),
    .i_compressed_instruction_mode(i_compressed_instruction_mode),
    .o_dma_gnt(o_dma_gnt), .o_bank_select_n(o_bank_select_n),
    .o_busy(o_busy), .o_done(o_done), .o_fault(o_fault),
    .o_kind(o_kind), .o_instr_per_fetch(o_instr_per_fetch)
);

/* tb/sdram_clk_model.sv */
// Memory side: free running memory clock, 125 ns period
module sdram_clk_model
(
    // Clock toward the block
    output logic o_sdram_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_sdram_clk = 1'b0;
        #3.3;
        forever #62.5 o_sdram_clk = ~o_sdram_clk;
    end
endmodule // sdram_clk_model

/* tb/test_external_memory_bank_map.sv */
`include "ext_bank_map.vh"
module test_external_memory_bank_map;
    timeunit 1ns;
    timeprecision 100ps;
    // Inputs, all given a value at time zero
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_sdram_clk;
    logic [3:0]  i_bank_is_sync = 4'h0;
    logic [11:0] i_bank_size_code = 12'hDB6;
    logic        i_ext_buffer_timing = 1'b0;
    logic        i_compressed_instruction_mode = 1'b0;
    logic        i_tim_we = 1'b0;
    logic [1:0]  i_tim_bank = 2'h0;
    logic [`TIME_W-1:0] i_tim_wait = 4'h0;
    logic        i_core_req = 1'b0;
    logic [31:0] i_core_addr = 32'h0;
    logic        i_core_fetch = 1'b0;
    logic        i_dma_req = 1'b0;
    logic [31:0] i_dma_addr = 32'h0;
    // Outputs and bench state
    wire         o_core_gnt, o_dma_gnt, o_busy, o_done, o_fault;
    wire [3:0]   o_bank_select_n;
    wire [1:0]   o_kind, o_instr_per_fetch;
    int          failures = 0, checks_done = 0, lat;
    logic [3:0]  sel_seen;
    logic [1:0]  kind_seen, ipf_seen;
    logic        flt;

    external_memory_bank_map DUT
    (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_sdram_clk(i_sdram_clk),
        .i_bank_is_sync(i_bank_is_sync), .i_tim_we(i_tim_we),
        .i_bank_size_code(i_bank_size_code), .i_tim_bank(i_tim_bank),
        .i_ext_buffer_timing(i_ext_buffer_timing), .i_tim_wait(i_tim_wait),
        .i_compressed_instruction_mode(i_compressed_instruction_mode),
        .i_core_req(i_core_req), .i_core_addr(i_core_addr),
        .i_core_fetch(i_core_fetch), .o_core_gnt(o_core_gnt),
        .i_dma_req(i_dma_req), .i_dma_addr(i_dma_addr), .o_busy(o_busy),
        .o_dma_gnt(o_dma_gnt), .o_bank_select_n(o_bank_select_n),
        .o_done(o_done), .o_fault(o_fault), .o_kind(o_kind),
        .o_instr_per_fetch(o_instr_per_fetch)
    );
    sdram_clk_model u_mem (.o_sdram_clk(i_sdram_clk));

    initial
    begin
        forever #4 i_mclk = ~i_mclk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Wait count for one bank, one cycle strobe
    task automatic set_wait(input logic [1:0] b, input logic [3:0] w);
        @(negedge i_mclk);
        {i_tim_we, i_tim_bank, i_tim_wait} = {1'b1, b, w};
        @(negedge i_mclk);
        i_tim_we = 1'b0;
    endtask

    // One transfer: hold request to grant, then track until done or fault
    task automatic access(input bit dma, input logic [31:0] a, input bit f);
        logic g;
        @(negedge i_mclk);
        {i_dma_req, i_core_req, i_core_fetch} = {dma, !dma, f};
        {i_dma_addr, i_core_addr} = {a, a};
        g = 1'b0;
        for (int n = 0; n < 50 && !g; n++)
        begin
            #2 g = dma ? o_dma_gnt : o_core_gnt;
            @(negedge i_mclk);
        end
        {i_dma_req, i_core_req} = 2'b00;
        sel_seen = 4'hF;
        for (lat = 1; lat < 200 && !(o_done || o_fault); lat++)
        begin
            if (o_bank_select_n !== 4'hF)
                {sel_seen, kind_seen, ipf_seen} =
                    {o_bank_select_n, o_kind, o_instr_per_fetch};
            @(negedge i_mclk);
        end
        flt = o_fault;
        check("granted", g, 1'b1);
        check("finished", lat < 200, 1'b1);
        while (o_busy === 1'b1)
            @(negedge i_mclk);
    endtask

    // Data access; a select of all ones means refusal expected
    task automatic probe(input logic [31:0] a, input logic [3:0] s);
        access(1'b0, a, 1'b0);
        check("bank select", sel_seen, s);
        check("fault", flt, s == 4'hF);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_arb;
        bit got_c, got_d, dma_first;
        @(negedge i_mclk);
        {i_core_req, i_dma_req} = 2'b11;
        {i_core_addr, i_dma_addr} = {32'h0020_0000, 32'h0400_0000};
        for (int n = 0; n < 100 && !(got_c && got_d); n++)
        begin
            #2 if (o_dma_gnt === 1'b1) dma_first = !got_c;
            got_d |= (o_dma_gnt === 1'b1);
            got_c |= (o_core_gnt === 1'b1);
            @(negedge i_mclk);
            {i_core_req, i_dma_req} = {i_core_req && !got_c,
                                       i_dma_req && !got_d};
        end
        check("both served", {got_c, got_d}, 2'b11);
        check("dma first", dma_first, 1'b1);
        while (o_busy === 1'b1)
            @(negedge i_mclk);
        $display("test arbitration done");
    endtask

    task automatic t_maps;
        probe(32'h0020_0000, 4'hE);
        probe(32'h007F_FFFF, 4'hE);
        probe(32'h0080_0000, 4'hF);
        probe(32'h087F_FFFF, 4'hB);
        probe(32'h0480_0000, 4'hF);
        probe(32'h001F_FFFF, 4'hF);
        i_bank_is_sync = 4'hF;
        probe(32'h03FF_FFFF, 4'hE);
        probe(32'h0400_0000, 4'hD);
        probe(32'h0FFF_FFFF, 4'h7);
        i_bank_size_code = 12'hD86;
        probe(32'h040F_FFFF, 4'hD);
        probe(32'h0410_0000, 4'hF);
        i_bank_is_sync = 4'h5;
        probe(32'h0880_0000, 4'hB);
        probe(32'h0480_0000, 4'hF);
        $display("test bank windows done");
    endtask

    // Fetches in both bank 0 windows pass; outside them they fault
    task automatic t_fetch;
        {i_bank_is_sync, i_bank_size_code} = {4'hF, 12'hDB6};
        access(1'b0, 32'h005F_FFFF, 1'b1);
        check("normal kind", {sel_seen, kind_seen}, 6'h39);
        i_compressed_instruction_mode = 1'b1;
        access(1'b0, 32'h00FF_FFFF, 1'b1);
        check("short kind", {sel_seen, kind_seen, ipf_seen}, 8'hEB);
        access(1'b0, 32'h0100_0000, 1'b1);
        check("fetch past window", flt, 1'b1);
        access(1'b0, 32'h0400_0000, 1'b1);
        check("fetch bank 1", flt, 1'b1);
        $display("test fetch done");
    endtask

    task automatic t_timing;
        int l1, l2;
        i_bank_is_sync = 4'h0;
        probe(32'h0400_0000, 4'hD);
        l1 = lat;
        probe(32'h0800_0000, 4'hB);
        l2 = lat;
        check("wait spread", l2 - l1, 2);
        i_ext_buffer_timing = 1'b1;
        probe(32'h0800_0000, 4'hB);
        check("buffer wait", lat - l2, 1);
        $display("test timing done");
    endtask

    initial
    begin
        repeat (16) @(negedge i_mclk);
        i_rst = 1'b0;
        check("reset selects", o_bank_select_n, 4'hF);
        for (int b = 0; b < 4; b++)
            set_wait(b[1:0], 4'(2 * b * b / 3));
        t_arb();
        t_maps();
        t_fetch();
        t_timing();
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge i_mclk);
        failures++;
        wrap_up();
    end
endmodule // test_external_memory_bank_map
